// ==== design/uart_baud_change_cmd.sv ====
// Rate-change command handler: receives the command packet, checks it, answers, reprograms the bit rate.
// Assumes rx/tx byte ports come from a serial engine on the same clock; txIdle is high once the last
// stop bit has left and drops no later than the cycle after a byte is handed over.
//
// Summary of operation
// - Bytes are dropped until the start byte, which opens a new packet.
// - A packet without the end byte gets a packet-error answer.
// - A wrong checksum gets a checksum-error answer.
// - A length breaking the packet format or this command's length gets packet error.
// - A pending encrypted write since reset gets a command-acceptance error.
// - Any error: do nothing, keep settings, go back to waiting.
// - Off the asynchronous link: skip parameter checks, answer OK, change nothing.
// - A rate above the reported maximum gets a parameter error.
// - Only the eight listed rates are accepted; others get a parameter error.
// - On success the OK answer goes out first, then the rate changes.
// - OK answer: 81, 00 0A, 34, 00, eight unused bytes, CA, 03.
// - Error answer: same frame, code B4, outcome code, unused detail and address.
// - Only the highest-priority error is reported, in the listed order.
// - Each rate loads double speed, prescaler, divisor and modulation from a table.
// - Any error leaves the serial bit rate unchanged.
// - No other boot link's speed is ever changed.
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps

module uart_baud_change_cmd (
  input  wire logic        clock,             // 250 MHz system clock
  input  wire logic        rst_n,             // Asynchronous reset, active low
  input  wire logic [7:0]  rxData,            // Received byte
  input  wire logic        rxValid,           // Received byte strobe
  output logic      [7:0]  txData,            // Response byte to transmitter
  output logic             txValid,           // Response byte valid
  input  wire logic        txReady,           // Transmitter takes the byte
  input  wire logic        txIdle,            // Transmitter fully empty
  input  wire logic [7:0]  regAddr,           // Register byte address
  input  wire logic [31:0] regWdata,          // Register write data
  input  wire logic        regWrite,          // Register write strobe
  input  wire logic        regRead,           // Register read strobe
  output logic      [31:0] regRdata,          // Read data, cycle after strobe
  output logic             doubleSpeedSelect, // Bit-rate double speed select
  output logic      [1:0]  prescalerSelect,   // Bit-rate clock prescaler
  output logic      [7:0]  rateDivisor,       // Bit-rate divisor
  output logic      [7:0]  rateModulation     // Bit-rate modulation value
);

  logic [1:0]            rstPipe_reg;
  logic                  rstSyncN;
  ubcc_pkg::ubcc_state_t state_reg;
  ubcc_pkg::ubcc_state_t state_next;
  logic [19:0]           lookup;
  logic                  otherCmd;
  logic                  errEtx;
  logic                  errSum;
  logic                  errFmt;
  logic                  errLen;
  logic                  errAcc;
  logic                  errMax;
  logic                  errRate;
  logic                  lastByte;

  // Rate table search: {hit, setting}
  function automatic logic [19:0] rateLookup(input logic [31:0] rate);
    logic [19:0] found;
    found = '0;
    for (int i = 0; i < 8; i++) begin
      if (rate == ubcc_pkg::RATE_VALUE[i]) begin
        found = {1'b1, ubcc_pkg::RATE_SETTING[i]};
      end
    end
    return found;
  endfunction : rateLookup

  // Response byte by position; the checksum makes the bytes from length to checksum sum to zero
  function automatic logic [7:0] respByte(input logic [3:0] idx, input logic [7:0] reply,
                                          input logic [7:0] outcome);
    logic [7:0] partial;
    partial = 8'(ubcc_pkg::RESP_LEN_LO + reply + outcome + ubcc_pkg::UNUSED_SUM);
    case (idx)
      4'h0:    return ubcc_pkg::RESP_START;
      4'h1:    return ubcc_pkg::RESP_LEN_HI;
      4'h2:    return ubcc_pkg::RESP_LEN_LO;
      4'h3:    return reply;
      4'h4:    return outcome;
      4'hd:    return 8'(8'h00 - partial);
      4'he:    return ubcc_pkg::FRAME_END;
      default: return ubcc_pkg::UNUSED_BYTE;
    endcase
  endfunction : respByte

  // Reset release through two flops; assertion is immediate, release is clocked
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_reg <= 2'b00;
    end else begin
      rstPipe_reg <= {rstPipe_reg[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe_reg[1];

  // Error conditions of the collected packet
  assign lookup   = rateLookup(state_reg.rate);
  assign otherCmd = (state_reg.len != 16'h0000) && (state_reg.cmd != ubcc_pkg::CMD_RATE);
  assign errEtx   = !state_reg.etxOk;
  assign errSum   = state_reg.sum != 8'h00;
  assign errFmt   = state_reg.len == 16'h0000;
  assign errLen   = state_reg.len != ubcc_pkg::CMD_RATE_LEN;
  assign errAcc   = state_reg.encPending;
  assign errMax   = state_reg.rate > state_reg.maxRate;
  assign errRate  = !lookup[19];
  assign lastByte = state_reg.cnt == ({1'b0, state_reg.len} + 17'h00001);

  // Next state of the whole handler
  always_comb begin
    state_next       = state_reg;
    state_next.rdata = '0;
    // Register reads answer zero at unmapped offsets
    if (regRead) begin
      case (regAddr)
        ubcc_pkg::REG_CTRL:     state_next.rdata = {30'h0, state_reg.encPending, state_reg.uartLink};
        ubcc_pkg::REG_MAX_RATE: state_next.rdata = state_reg.maxRate;
        ubcc_pkg::REG_STATUS:   state_next.rdata = {15'h0, state_reg.phase != ubcc_pkg::PH_WAIT,
                                                    state_reg.reply, state_reg.outcome};
        ubcc_pkg::REG_RATE:     state_next.rdata = {13'h0, state_reg.curSet};
        default:                state_next.rdata = '0;
      endcase
    end
    // Register writes; unmapped writes are dropped
    if (regWrite) begin
      if (regAddr == ubcc_pkg::REG_CTRL) begin
        state_next.uartLink   = regWdata[ubcc_pkg::CTRL_UART_BIT];
        state_next.encPending = regWdata[ubcc_pkg::CTRL_ENC_BIT];
      end
      if (regAddr == ubcc_pkg::REG_MAX_RATE) begin
        state_next.maxRate = regWdata;
      end
    end
    unique case (state_reg.phase)
      ubcc_pkg::PH_WAIT: begin
        // Anything but the start byte is dropped here
        if (rxValid && rxData == ubcc_pkg::CMD_START) begin
          state_next.phase = ubcc_pkg::PH_LENHI;
          state_next.rate  = '0;
          state_next.cmd   = '0;
        end
      end
      ubcc_pkg::PH_LENHI: begin
        if (rxValid) begin
          state_next.len[15:8] = rxData;
          state_next.sum       = rxData;
          state_next.phase     = ubcc_pkg::PH_LENLO;
        end
      end
      ubcc_pkg::PH_LENLO: begin
        if (rxValid) begin
          state_next.len[7:0] = rxData;
          state_next.sum      = 8'(state_reg.sum + rxData);
          state_next.cnt      = '0;
          state_next.phase    = ubcc_pkg::PH_BODY;
        end
      end
      ubcc_pkg::PH_BODY: begin
        // The declared length decides where checksum and end byte sit
        if (rxValid) begin
          if (lastByte) begin
            state_next.etxOk = rxData == ubcc_pkg::FRAME_END;
            state_next.phase = ubcc_pkg::PH_CHECK;
          end else begin
            state_next.sum = 8'(state_reg.sum + rxData);
            state_next.cnt = 17'(state_reg.cnt + 17'h00001);
            if (state_reg.cnt == 17'h00000) begin
              state_next.cmd = rxData;
            end
            if (state_reg.cnt >= 17'h00001 && state_reg.cnt <= 17'h00004) begin
              state_next.rate = {state_reg.rate[23:0], rxData};
            end
          end
        end
      end
      ubcc_pkg::PH_CHECK: begin
        // Error priority follows the order of the tests
        state_next.reply   = ubcc_pkg::REPLY_ERR;
        state_next.apply   = 1'b0;
        state_next.newSet  = lookup[18:0];
        if (errEtx || errSum || errFmt || errLen) begin
          state_next.outcome = errEtx ? ubcc_pkg::OUT_PACKET : errSum ? ubcc_pkg::OUT_CHECKSUM
                             : ubcc_pkg::OUT_PACKET;
        end else if (errAcc) begin
          state_next.outcome = ubcc_pkg::OUT_ACCEPT;
        end else if (!state_reg.uartLink) begin
          state_next.reply   = ubcc_pkg::REPLY_OK;
          state_next.outcome = ubcc_pkg::OUT_OK;
        end else if (errMax || errRate) begin
          state_next.outcome = ubcc_pkg::OUT_PARAM;
        end else begin
          state_next.reply   = ubcc_pkg::REPLY_OK;
          state_next.outcome = ubcc_pkg::OUT_OK;
          state_next.apply   = 1'b1;
        end
        // Packets of other commands belong to other handlers and get no answer
        if (otherCmd && !errFmt) begin
          state_next.phase = ubcc_pkg::PH_WAIT;
          state_next.reply   = state_reg.reply;
          state_next.outcome = state_reg.outcome;
          state_next.apply   = 1'b0;
        end else begin
          state_next.phase   = ubcc_pkg::PH_SEND;
          state_next.txIdx   = 4'h0;
          state_next.txValid = 1'b1;
          state_next.txData  = ubcc_pkg::RESP_START;
        end
      end
      ubcc_pkg::PH_SEND: begin
        // Bytes stand until the transmitter takes them
        if (txReady) begin
          if (state_reg.txIdx == ubcc_pkg::RESP_LAST_IDX) begin
            state_next.txValid  = 1'b0;
            state_next.seenBusy = 1'b0;
            state_next.phase    = state_reg.apply ? ubcc_pkg::PH_DRAIN : ubcc_pkg::PH_WAIT;
          end else begin
            state_next.txIdx  = 4'(state_reg.txIdx + 4'h1);
            state_next.txData = respByte(4'(state_reg.txIdx + 4'h1), state_reg.reply, state_reg.outcome);
          end
        end
      end
      ubcc_pkg::PH_DRAIN: begin
        // Busy must be seen first, else an idle flag before loading would cut the answer short
        if (!txIdle) begin
          state_next.seenBusy = 1'b1;
        end
        if (state_reg.seenBusy && txIdle) begin
          state_next.curSet = state_reg.newSet;
          state_next.phase  = ubcc_pkg::PH_WAIT;
        end
      end
      default: begin
        state_next.phase   = ubcc_pkg::PH_WAIT;
        state_next.txValid = 1'b0;
      end
    endcase
  end

  // All handler state in one register; reset gives waiting phase and boot rate
  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_reg <= ubcc_pkg::STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign txData            = state_reg.txData;
  assign txValid           = state_reg.txValid;
  assign regRdata          = state_reg.rdata;
  assign doubleSpeedSelect = state_reg.curSet[18];
  assign prescalerSelect   = state_reg.curSet[17:16];
  assign rateDivisor       = state_reg.curSet[15:8];
  assign rateModulation    = state_reg.curSet[7:0];

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstSyncN);

  wait_discard_a : assert property (
    (state_reg.phase == ubcc_pkg::PH_WAIT && rxValid && rxData != ubcc_pkg::CMD_START)
    |=> state_reg.phase == ubcc_pkg::PH_WAIT) else $error("non-start byte left waiting");

  etx_error_a : assert property (
    (state_reg.phase == ubcc_pkg::PH_CHECK && errEtx && !(otherCmd && !errFmt))
    |=> (state_reg.outcome == ubcc_pkg::OUT_PACKET && state_reg.reply == ubcc_pkg::REPLY_ERR))
    else $error("missing end byte not reported");

  sum_error_a : assert property (
    (state_reg.phase == ubcc_pkg::PH_CHECK && !errEtx && errSum && !(otherCmd && !errFmt))
    |=> state_reg.outcome == ubcc_pkg::OUT_CHECKSUM) else $error("checksum error not reported");

  accept_error_a : assert property (
    (state_reg.phase == ubcc_pkg::PH_CHECK && state_reg.etxOk && !errSum && !errLen && errAcc && !otherCmd)
    |=> (state_reg.outcome == ubcc_pkg::OUT_ACCEPT && !state_reg.apply)) else $error("acceptance error lost");

  other_link_a : assert property (
    (state_reg.phase == ubcc_pkg::PH_CHECK && state_reg.etxOk && !errSum && !errLen && !errAcc
     && !state_reg.uartLink && !otherCmd) |=> (state_reg.outcome == ubcc_pkg::OUT_OK && !state_reg.apply))
    else $error("other link answer wrong");

  rate_param_a : assert property (
    (state_reg.phase == ubcc_pkg::PH_CHECK && state_reg.etxOk && !errSum && !errLen && !errAcc
     && state_reg.uartLink && !lookup[19] && !otherCmd) |=> state_reg.outcome == ubcc_pkg::OUT_PARAM)
    else $error("unsupported rate accepted");

  frame_start_a : assert property (
    (state_reg.txValid && state_reg.txIdx == 4'h0) |-> state_reg.txData == ubcc_pkg::RESP_START)
    else $error("response does not open with start byte");

  ok_sum_a : assert property (
    (state_reg.txValid && state_reg.txIdx == 4'hd && state_reg.reply == ubcc_pkg::REPLY_OK)
    |-> state_reg.txData == 8'hca) else $error("OK response checksum wrong");

  tx_hold_a : assert property (
    (state_reg.txValid && !txReady) |=> (state_reg.txValid && $stable(state_reg.txData)))
    else $error("response byte dropped before taken");

  apply_late_a : assert property (
    !$stable(state_reg.curSet) |-> ($past(state_reg.phase) == ubcc_pkg::PH_DRAIN && $past(txIdle)
     && $past(state_reg.seenBusy))) else $error("rate changed outside drain");

  error_keep_a : assert property (
    (state_reg.phase == ubcc_pkg::PH_SEND && state_reg.reply == ubcc_pkg::REPLY_ERR)
    |=> ($stable(state_reg.curSet) && state_reg.phase != ubcc_pkg::PH_DRAIN)) else $error("error changed rate");

endmodule : uart_baud_change_cmd

// ==== design/ubcc_pkg.sv ====
// Constants, types and reset values of the serial rate-change command handler.
// Assumes a byte-wide serial receiver and transmitter on the same clock.
package ubcc_pkg;

  // Packet framing bytes
  localparam logic [7:0]  CMD_START      = 8'h01;
  localparam logic [7:0]  FRAME_END      = 8'h03;
  localparam logic [7:0]  CMD_RATE       = 8'h34;
  localparam logic [15:0] CMD_RATE_LEN   = 16'h0005;
  localparam logic [7:0]  RESP_START     = 8'h81;
  localparam logic [7:0]  RESP_LEN_HI    = 8'h00;
  localparam logic [7:0]  RESP_LEN_LO    = 8'h0a;
  localparam logic [7:0]  REPLY_OK       = 8'h34;
  localparam logic [7:0]  REPLY_ERR      = 8'hb4;
  localparam logic [7:0]  UNUSED_BYTE    = 8'hff;
  localparam logic [7:0]  UNUSED_SUM     = 8'hf8;  // Eight unused bytes, summed modulo 256
  localparam logic [3:0]  RESP_LAST_IDX  = 4'he;   // Fifteen bytes per response

  // Outcome codes
  localparam logic [7:0]  OUT_OK         = 8'h00;
  localparam logic [7:0]  OUT_PACKET     = 8'hc1;
  localparam logic [7:0]  OUT_CHECKSUM   = 8'hc2;
  localparam logic [7:0]  OUT_ACCEPT     = 8'hc3;
  localparam logic [7:0]  OUT_PARAM      = 8'hc4;

  // Register offsets and fields
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_MAX_RATE   = 8'h04;
  localparam logic [7:0]  REG_STATUS     = 8'h08;
  localparam logic [7:0]  REG_RATE       = 8'h0c;
  localparam int          CTRL_UART_BIT  = 0;
  localparam int          CTRL_ENC_BIT   = 1;
  localparam int          STATUS_BUSY_BIT = 16;
  localparam logic [31:0] MAX_RATE_RST   = 32'h005b8d80;

  // Supported rates, index 0 lowest; settings are {double speed, prescaler, divisor, modulation}
  localparam logic [7:0][31:0] RATE_VALUE = {32'h005b8d80, 32'h003d0900, 32'h001e8480, 32'h0016e360,
                                             32'h000f4240, 32'h0007a120, 32'h0001c200, 32'h00002580};
  localparam logic [7:0][18:0] RATE_SETTING = {{1'b1, 2'b00, 8'h00, 8'hf5}, {1'b1, 2'b00, 8'h00, 8'ha3},
                                               {1'b0, 2'b00, 8'h00, 8'ha3}, {1'b0, 2'b00, 8'h01, 8'hf5},
                                               {1'b0, 2'b00, 8'h02, 8'hf5}, {1'b0, 2'b00, 8'h05, 8'hf5},
                                               {1'b0, 2'b00, 8'h1a, 8'hfe}, {1'b0, 2'b00, 8'hff, 8'hc9}};
  localparam logic [18:0] SETTING_RST    = {1'b0, 2'b00, 8'hff, 8'hc9};

  typedef enum logic [6:0] {
    PH_WAIT  = 7'h01,
    PH_LENHI = 7'h02,
    PH_LENLO = 7'h04,
    PH_BODY  = 7'h08,
    PH_CHECK = 7'h10,
    PH_SEND  = 7'h20,
    PH_DRAIN = 7'h40
  } ubcc_phase_t;

  typedef struct packed {
    ubcc_phase_t  phase;
    logic [15:0]  len;
    logic [16:0]  cnt;
    logic [7:0]   sum;
    logic [7:0]   cmd;
    logic [31:0]  rate;
    logic         etxOk;
    logic         apply;
    logic         seenBusy;
    logic [7:0]   reply;
    logic [7:0]   outcome;
    logic [3:0]   txIdx;
    logic [7:0]   txData;
    logic         txValid;
    logic [18:0]  newSet;
    logic [18:0]  curSet;
    logic         uartLink;
    logic         encPending;
    logic [31:0]  maxRate;
    logic [31:0]  rdata;
  } ubcc_state_t;

  localparam ubcc_state_t STATE_RST = '{phase: PH_WAIT, curSet: SETTING_RST, newSet: SETTING_RST,
                                        uartLink: 1'b1, maxRate: MAX_RATE_RST, default: '0};

endpackage : ubcc_pkg

// ==== dv/ubcc_host_model.sv ====
// Host-side transmitter model: takes response bytes and reports when the line is empty.
// Assumes the handler's byte handshake on the same clock; slowMode adds stalls and longer bytes.
`timescale 1ns/10ps

module ubcc_host_model (
  input  wire logic clock,    // System clock
  input  wire logic rst_n,    // Reset, active low
  input  wire logic txValid,  // Byte offered
  input  wire logic slowMode, // Stalls and slow bytes
  output logic      txReady,  // Byte taken at this edge
  output logic      txIdle    // Last stop bit gone
);
  logic [5:0] busyCnt;
  logic       go;

  // No holding register, so each byte waits until the previous stop bit is out
  assign txReady = go && (busyCnt == 6'h00);
  assign txIdle  = (busyCnt == 6'h00);

  // Byte time counts down after each take
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busyCnt <= 6'h00;
      go      <= 1'b0;
    end else begin
      go <= !slowMode || ($urandom_range(0, 2) == 0);
      if (txValid && txReady)
        busyCnt <= slowMode ? 6'h30 : 6'h0a;
      else if (busyCnt != 6'h00)
        busyCnt <= busyCnt - 6'h01;
    end
  end
endmodule : ubcc_host_model

// ==== dv/uart_baud_change_cmd_tb.sv ====
// Self-checking bench of the rate-change handler: every rate, every error but a wrong non-zero length, random gaps and stalls.
// Assumes the host model stands in for the transmitter; the bench plays the host on the receive side.
`timescale 1ns/10ps

module uart_baud_change_cmd_tb;
  logic        clock    = 1'b0;
  logic        rst_n    = 1'b0;
  logic [7:0]  rxData   = 8'h00;
  logic        rxValid  = 1'b0;
  logic [7:0]  regAddr  = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic        regWrite = 1'b0;
  logic        regRead  = 1'b0;
  logic        slowMode = 1'b0;
  logic [7:0]  txData;
  logic        txValid;
  logic        txReady;
  logic        txIdle;
  logic [31:0] regRdata;
  logic        dsSel;
  logic [1:0]  preSel;
  logic [7:0]  rateDiv;
  logic [7:0]  rateMod;
  int          err_total       = 0;
  int          samples_checked = 0;
  logic [7:0]  pkt[$];
  logic [7:0]  resp[$];
  logic [31:0] rdVal;
  logic [18:0] curSet;
  int          k;

  // Supported rates lowest first, and {double speed, prescaler, divisor, modulation} for each
  localparam logic [31:0] RATES [8] = '{32'h00002580, 32'h0001c200, 32'h0007a120, 32'h000f4240,
                                        32'h0016e360, 32'h001e8480, 32'h003d0900, 32'h005b8d80};
  localparam logic [18:0] SETS [8]  = '{19'h0ffc9, 19'h01afe, 19'h005f5, 19'h002f5,
                                        19'h001f5, 19'h000a3, 19'h400a3, 19'h400f5};
  localparam logic [7:0]  ADDRS [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'hfc};
  localparam logic [31:0] RSTV [6]  = '{32'h1, 32'h005b8d80, 32'h0, 32'h0000ffc9, 32'h0, 32'h0};

  always #2 clock = ~clock;

  uart_baud_change_cmd DUT (
    .clock(clock), .rst_n(rst_n), .rxData(rxData), .rxValid(rxValid), .txData(txData),
    .txValid(txValid), .txReady(txReady), .txIdle(txIdle), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .doubleSpeedSelect(dsSel),
    .prescalerSelect(preSel), .rateDivisor(rateDiv), .rateModulation(rateMod)
  );

  ubcc_host_model host (
    .clock(clock), .rst_n(rst_n), .txValid(txValid), .slowMode(slowMode), .txReady(txReady), .txIdle(txIdle)
  );

  // Collect each response byte half a cycle before the edge that takes it
  always @(negedge clock) begin
    if (txValid === 1'b1 && txReady === 1'b1)
      resp.push_back(txData);
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // Register tasks start just after an edge
  task automatic reg_wr(input logic [7:0] addr, input logic [31:0] data);
    regAddr  <= addr;
    regWdata <= data;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    // One idle edge, so a following write never sets the strobe in the step that clears it
    @(posedge clock);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] addr, output logic [31:0] data);
    regAddr <= addr;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    data = regRdata;
    @(posedge clock);
  endtask : reg_rd

  // Junk bytes never equal the start byte; sumFix spoils the checksum on purpose
  task automatic build(input int junk, input logic [15:0] len, input logic [31:0] rate,
                       input logic [7:0] sumFix, input logic [7:0] endB);
    logic [7:0] s;
    logic [7:0] body[$];
    body = {len[15:8], len[7:0]};
    if (len != 16'h0000)
      body = {body, 8'h34, rate[31:24], rate[23:16], rate[15:8], rate[7:0]};
    s = sumFix;
    foreach (body[i])
      s -= body[i];
    pkt.delete();
    repeat (junk) pkt.push_back({1'b1, 7'($urandom)});
    pkt = {pkt, 8'h01, body, s, endB};
  endtask : build

  // Send pkt with random gaps; a gap shows the inverted byte so a stray sample is caught
  task automatic send_pkt();
    foreach (pkt[i]) begin
      rxData  <= pkt[i];
      rxValid <= 1'b1;
      @(posedge clock);
      if ($urandom_range(0, 3) == 0) begin
        rxValid <= 1'b0;
        rxData  <= ~pkt[i];
        @(posedge clock);
      end
    end
    rxValid <= 1'b0;
    rxData  <= 8'($urandom);
  endtask : send_pkt

  // Send pkt, check the answer, the setting during and after it, and the status register
  task automatic run_cmd(input logic [7:0] code, input logic [18:0] expSet);
    logic [7:0] reply;
    logic [7:0] exp[15];
    int         n;
    reply = (code == 8'h00) ? 8'h34 : 8'hb4;
    exp = '{8'h81, 8'h00, 8'h0a, reply, code, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
            8'h00 - (8'h0a + reply + code + 8'hf8), 8'h03};
    slowMode <= 1'($urandom_range(0, 1));
    resp.delete();
    send_pkt();
    for (n = 0; n < 4000 && resp.size() < 15; n++)
      @(posedge clock);
    #1;
    if (resp.size() < 15) begin
      check("answer length", resp.size(), 15);
      stop_test();
    end
    check("rate at last byte", {dsSel, preSel, rateDiv, rateMod}, curSet);
    foreach (exp[i])
      check("answer byte", resp[i], exp[i]);
    // Looked at a step after each edge; the old rate must still stand when the line goes empty
    for (n = 0; n < 200 && txIdle !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    if (txIdle !== 1'b1) begin
      check("line empty", txIdle, 1'b1);
      stop_test();
    end
    check("rate when empty", {dsSel, preSel, rateDiv, rateMod}, curSet);
    // Short gap instead of a millisecond: the handler refuses nothing once back in waiting
    repeat (3) @(posedge clock);
    check("rate after answer", {dsSel, preSel, rateDiv, rateMod}, expSet);
    reg_rd(8'h08, rdVal);
    check("status", {rdVal[16], rdVal[15:0]}, {1'b0, reply, code});
    curSet = expSet;
  endtask : run_cmd

  // Main sequence
  initial begin
    void'($urandom(32'h8d064ad1));
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    curSet = 19'h0ffc9;
    check("tx valid after reset", txValid, 1'b0);
    reg_wr(8'h08, 32'hffffffff);
    reg_wr(8'h10, 32'hffffffff);
    for (k = 0; k < 6; k++) begin
      reg_rd(ADDRS[k], rdVal);
      check("register reset", rdVal, RSTV[k]);
    end
    // Every rate, starting above the boot rate so each one changes the setting
    for (k = 1; k <= 8; k++) begin
      build($urandom_range(0, 3), 16'h0005, RATES[k % 8], 8'h00, 8'h03);
      run_cmd(8'h00, SETS[k % 8]);
    end
    build(0, 16'h0005, RATES[3], 8'h00, 8'h04);
    run_cmd(8'hc1, curSet);
    build(0, 16'h0005, RATES[3], 8'h01, 8'h03);
    run_cmd(8'hc2, curSet);
    build(0, 16'h0000, 32'h0, 8'h00, 8'h03);
    run_cmd(8'hc1, curSet);
    build(1, 16'h0005, RATES[$urandom_range(0, 7)] ^ 32'h00000100, 8'h00, 8'h03);
    run_cmd(8'hc4, curSet);
    reg_wr(8'h00, 32'h3);
    build(0, 16'h0005, RATES[3], 8'h01, 8'h03);
    run_cmd(8'hc2, curSet);
    build(0, 16'h0005, RATES[3], 8'h00, 8'h03);
    run_cmd(8'hc3, curSet);
    reg_wr(8'h04, RATES[3]);
    build(0, 16'h0005, RATES[4], 8'h00, 8'h03);
    run_cmd(8'hc3, curSet);
    reg_wr(8'h00, 32'h1);
    run_cmd(8'hc4, curSet);
    build(0, 16'h0005, RATES[3], 8'h00, 8'h03);
    run_cmd(8'h00, SETS[3]);
    reg_wr(8'h04, 32'h005b8d80);
    reg_wr(8'h00, 32'h0);
    build(0, 16'h0005, RATES[7], 8'h00, 8'h03);
    run_cmd(8'h00, curSet);
    build(2, 16'h0005, 32'h12345678, 8'h00, 8'h03);
    run_cmd(8'h00, curSet);
    // Another command code with a fixed-up checksum belongs to another handler: no answer, no change
    build(0, 16'h0005, RATES[2], 8'h00, 8'h03);
    pkt[3] = 8'h12;
    pkt[8] = pkt[8] + 8'h22;
    resp.delete();
    send_pkt();
    repeat (40) @(posedge clock);
    check("ignored command answer", resp.size(), 0);
    check("rate after ignored", {dsSel, preSel, rateDiv, rateMod}, curSet);
    stop_test();
  end
endmodule : uart_baud_change_cmd_tb
